// ==== trng_health_map.vh ====
// Register offsets, field positions and default values of the entropy health register group.
`ifndef TRNG_HEALTH_MAP_VH
`define TRNG_HEALTH_MAP_VH
`define OFS_MISC_CONTROL 12'h600
`define OFS_POKER_SPAN 12'h608
`define OFS_POKER_LIMIT 12'h60C
`define OFS_SAMPLE_TIMING 12'h610
`define OFS_SPARSE_LIMIT 12'h614
`define OFS_FREQ_LOWER 12'h618
`define OFS_FREQ_UPPER 12'h61C
`define OFS_OSC2_CONTROL 12'h630
`define BIT_PROGRAM_MODE 16
`define BIT_ERROR_STATUS 12
`define BIT_FREQ_VALID 9
`define BIT_FREQ_FAIL 8
`define BIT_RESTORE 6
`define BIT_ACCESS_MODE 5
`define DEF_POKER_LIMIT 24'h006920
`define DEF_POKER_SPAN 16'h09A3
`define DEF_SAMPLE_LENGTH 16'h0C80
`define DEF_SAMPLE_COUNT 16'h09C4
`define DEF_SPARSE_LIMIT 10'h03F
`define DEF_FREQ_LOWER 22'h000190
`define DEF_FREQ_UPPER 22'h006400
`define DEF_SAMPLING 2'h1
`define SAMPLING_VN_BOTH 2'h0
`define SAMPLING_RAW_BOTH 2'h1
`define SAMPLING_VN_SHIFT 2'h2
`define ENTROPY_SEL_OFF 2'h2
`endif

// ==== sample_timer.v ====
// Sample period and sample count timer for one entropy generation run.
`timescale 1ns/1ps
module sample_timer #(
    parameter LEN_W = 16,
    parameter CNT_W = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire start_i,
    input wire [LEN_W-1:0] length_i,
    input wire [CNT_W-1:0] count_i,
    output reg busy_o,
    output reg period_end_o,
    output reg done_o
);
    reg [LEN_W-1:0] tick_q;
    reg [CNT_W-1:0] left_q;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            period_end_o <= 1'b0;
            done_o <= 1'b0;
            tick_q <= {LEN_W{1'b0}};
            left_q <= {CNT_W{1'b0}};
        end else begin
            period_end_o <= 1'b0;
            done_o <= 1'b0;
            if (!busy_o) begin
                if (start_i && count_i != {CNT_W{1'b0}}) begin
                    busy_o <= 1'b1;
                    tick_q <= {LEN_W{1'b0}};
                    left_q <= count_i;
                end
            end else if (tick_q + {{(LEN_W-1){1'b0}}, 1'b1} >= length_i) begin
                // Each period lasts the programmed number of system clocks, at least one.
                tick_q <= {LEN_W{1'b0}};
                period_end_o <= 1'b1;
                left_q <= left_q - {{(CNT_W-1){1'b0}}, 1'b1};
                if (left_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end else begin
                tick_q <= tick_q + {{(LEN_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // sample_timer

// ==== vn_filter.v ====
// Von Neumann pair filter with consecutive discard counting.
`timescale 1ns/1ps
module vn_filter #(
    parameter LIM_W = 10
) (
    input wire clk_i,
    input wire rst_i,
    input wire enable_i,
    input wire sample_i,
    input wire valid_i,
    input wire [LIM_W-1:0] limit_i,
    output reg bit_o,
    output reg bit_valid_o,
    output reg sparse_fail_o
);
    reg first_q;
    reg have_q;
    reg [LIM_W:0] discards_q;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_q <= 1'b0;
            have_q <= 1'b0;
            discards_q <= {(LIM_W+1){1'b0}};
            bit_o <= 1'b0;
            bit_valid_o <= 1'b0;
            sparse_fail_o <= 1'b0;
        end else begin
            bit_valid_o <= 1'b0;
            sparse_fail_o <= 1'b0;
            if (!enable_i) begin
                have_q <= 1'b0;
                discards_q <= {(LIM_W+1){1'b0}};
            end else if (valid_i) begin
                if (!have_q) begin
                    first_q <= sample_i;
                    have_q <= 1'b1;
                end else begin
                    have_q <= 1'b0;
                    if (first_q == sample_i) begin
                        discards_q <= discards_q + {{LIM_W{1'b0}}, 1'b1};
                        if (discards_q + {{LIM_W{1'b0}}, 1'b1} > {1'b0, limit_i}) begin
                            sparse_fail_o <= 1'b1;
                        end
                    end else begin
                        discards_q <= {(LIM_W+1){1'b0}};
                        bit_o <= first_q;
                        bit_valid_o <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // vn_filter

// ==== trng_health_limits.v ====
// Entropy source health limit registers with an AHB-Lite slave and a compact health checker.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "trng_health_map.vh"
module trng_health_limits #(
    parameter FREQ_W = 22,
    parameter TOTAL_W = 20
) (
    input wire clk_i,
    input wire rst_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    input wire osc_i,
    input wire raw_bit_i,
    input wire start_i,
    output reg busy_o,
    output reg error_o
);
    // Control and limit registers.
    reg program_mode_q;
    reg access_mode_q;
    reg [1:0] sampling_method_q;
    reg [1:0] entropy_select_q;
    reg [23:0] poker_limit_q;
    reg [15:0] poker_span_q;
    reg [15:0] sample_length_q;
    reg [15:0] sample_count_q;
    reg [9:0] sparse_limit_q;
    reg [FREQ_W-1:0] freq_lower_q;
    reg [FREQ_W-1:0] freq_upper_q;
    // Result state.
    reg [23:0] poker_square_q;
    reg [TOTAL_W-1:0] total_q;
    reg [FREQ_W-1:0] freq_count_q;
    reg [FREQ_W-1:0] osc_edges_q;
    reg freq_valid_q;
    reg freq_fail_q;
    reg error_q;
    reg [3:0] nibble_q;
    reg [1:0] nibble_bits_q;
    reg [15:0] hist_q [0:15];
    // Bus and pin state.
    reg wr_pending_q;
    reg [11:0] addr_q;
    reg osc_meta_q;
    reg osc_sync_q;
    reg osc_prev_q;
    reg raw_meta_q;
    reg raw_sync_q;
    integer i;

    wire timer_busy;
    wire period_end;
    wire run_done;
    wire vn_bit;
    wire vn_valid;
    wire sparse_fail;
    wire use_vn_checker;
    wire checker_bit;
    wire checker_valid;
    wire osc_rise;
    wire [FREQ_W-1:0] period_edges;
    wire freq_low;
    wire freq_high;
    wire [24:0] poker_min;
    wire poker_fail;
    wire [23:0] square_of_bin;
    wire access_now;
    wire write_now;
    wire [11:0] req_addr;
    wire write_program;
    wire restore;

    function [31:0] pad;
        input [23:0] value;
        begin
            pad = {8'h00, value};
        end
    endfunction

    // Each nibble pushes the poker value down by the square of its bin's count so far.
    function [23:0] square16;
        input [15:0] value;
        reg [31:0] prod;
        begin
            prod = value * value;
            square16 = prod[23:0];
        end
    endfunction

    assign access_now = hsel_i && htrans_i[1] && hready_i;
    assign write_now = access_now && hwrite_i;
    assign req_addr = haddr_i[11:0];
    assign write_program = wr_pending_q && addr_q == `OFS_MISC_CONTROL;
    // Restore is honoured with program mode already set or being set now.
    assign restore = write_program && hwdata_i[`BIT_RESTORE] &&
        (program_mode_q || hwdata_i[`BIT_PROGRAM_MODE]);
    assign use_vn_checker = sampling_method_q == `SAMPLING_VN_BOTH;
    assign checker_bit = use_vn_checker ? vn_bit : raw_sync_q;
    // One raw sample is taken at the end of each sample period, not on every clock.
    assign checker_valid = use_vn_checker ? vn_valid : period_end;
    assign osc_rise = osc_sync_q && !osc_prev_q;
    assign period_edges = osc_edges_q + {{(FREQ_W-1){1'b0}}, osc_rise};
    assign freq_low = period_edges < freq_lower_q;
    assign freq_high = period_edges > freq_upper_q;
    assign poker_min = {1'b0, poker_limit_q} - {9'h000, poker_span_q} + 25'h0000001;
    assign poker_fail = poker_square_q == 24'h000000 ||
        poker_square_q >= {8'h00, poker_span_q};
    assign square_of_bin = square16(hist_q[{nibble_q[2:0], checker_bit}]);

    sample_timer #(
        .LEN_W(16),
        .CNT_W(16)
    ) timer_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(start_i && !program_mode_q),
        .length_i(sample_length_q),
        .count_i(sample_count_q),
        .busy_o(timer_busy),
        .period_end_o(period_end),
        .done_o(run_done)
    );

    vn_filter #(
        .LIM_W(10)
    ) vn_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(timer_busy && sampling_method_q != `SAMPLING_RAW_BOTH),
        .sample_i(raw_sync_q),
        .valid_i(period_end),
        .limit_i(sparse_limit_q),
        .bit_o(vn_bit),
        .bit_valid_o(vn_valid),
        .sparse_fail_o(sparse_fail)
    );

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
            osc_prev_q <= 1'b0;
            raw_meta_q <= 1'b0;
            raw_sync_q <= 1'b0;
        end else begin
            osc_meta_q <= osc_i;
            osc_sync_q <= osc_meta_q;
            osc_prev_q <= osc_sync_q;
            raw_meta_q <= raw_bit_i;
            raw_sync_q <= raw_meta_q;
        end
    end

    // Bus address phase capture and register writes in the data phase.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pending_q <= 1'b0;
            addr_q <= 12'h000;
            program_mode_q <= 1'b0;
            access_mode_q <= 1'b0;
            sampling_method_q <= `DEF_SAMPLING;
            entropy_select_q <= 2'h0;
            poker_limit_q <= `DEF_POKER_LIMIT;
            poker_span_q <= `DEF_POKER_SPAN;
            sample_length_q <= `DEF_SAMPLE_LENGTH;
            sample_count_q <= `DEF_SAMPLE_COUNT;
            sparse_limit_q <= `DEF_SPARSE_LIMIT;
            freq_lower_q <= `DEF_FREQ_LOWER;
            freq_upper_q <= `DEF_FREQ_UPPER;
        end else begin
            wr_pending_q <= write_now;
            if (access_now) begin
                addr_q <= req_addr;
            end
            if (write_program) begin
                program_mode_q <= hwdata_i[`BIT_PROGRAM_MODE];
                access_mode_q <= hwdata_i[`BIT_ACCESS_MODE];
                if (program_mode_q || hwdata_i[`BIT_PROGRAM_MODE]) begin
                    sampling_method_q <= hwdata_i[1:0];
                end
            end
            if (wr_pending_q && addr_q == `OFS_OSC2_CONTROL) begin
                entropy_select_q <= hwdata_i[1:0];
            end
            if (restore) begin
                poker_limit_q <= `DEF_POKER_LIMIT;
                poker_span_q <= `DEF_POKER_SPAN;
                sample_length_q <= `DEF_SAMPLE_LENGTH;
                sample_count_q <= `DEF_SAMPLE_COUNT;
                sparse_limit_q <= `DEF_SPARSE_LIMIT;
                freq_lower_q <= `DEF_FREQ_LOWER;
                freq_upper_q <= `DEF_FREQ_UPPER;
                sampling_method_q <= `DEF_SAMPLING;
            end else if (wr_pending_q && program_mode_q) begin
                case (addr_q)
                    `OFS_POKER_SPAN: poker_span_q <= hwdata_i[15:0];
                    `OFS_POKER_LIMIT: poker_limit_q <= hwdata_i[23:0];
                    `OFS_SAMPLE_TIMING: begin
                        sample_length_q <= hwdata_i[31:16];
                        sample_count_q <= hwdata_i[15:0];
                    end
                    `OFS_SPARSE_LIMIT: sparse_limit_q <= hwdata_i[9:0];
                    `OFS_FREQ_LOWER: freq_lower_q <= hwdata_i[FREQ_W-1:0];
                    `OFS_FREQ_UPPER: freq_upper_q <= hwdata_i[FREQ_W-1:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Health checks during a generation run.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            poker_square_q <= 24'h000000;
            total_q <= {TOTAL_W{1'b0}};
            freq_count_q <= {FREQ_W{1'b0}};
            osc_edges_q <= {FREQ_W{1'b0}};
            freq_valid_q <= 1'b0;
            freq_fail_q <= 1'b0;
            error_q <= 1'b0;
            nibble_q <= 4'h0;
            nibble_bits_q <= 2'h0;
            for (i = 0; i < 16; i = i + 1) begin
                hist_q[i] <= 16'h0000;
            end
        end else begin
            if (start_i && !timer_busy && !program_mode_q) begin
                total_q <= {TOTAL_W{1'b0}};
                osc_edges_q <= {FREQ_W{1'b0}};
                freq_valid_q <= 1'b0;
                poker_square_q <= poker_limit_q;
                nibble_bits_q <= 2'h0;
                for (i = 0; i < 16; i = i + 1) begin
                    hist_q[i] <= 16'h0000;
                end
            end else if (timer_busy || period_end) begin
                // The last period ends as the timer drops busy, so its pulse is still taken here.
                if (period_end) begin
                    total_q <= total_q + {{(TOTAL_W-1){1'b0}}, 1'b1};
                    freq_count_q <= period_edges;
                    freq_valid_q <= 1'b1;
                    osc_edges_q <= {FREQ_W{1'b0}};
                end else begin
                    osc_edges_q <= period_edges;
                end
                if (checker_valid) begin
                    nibble_q <= {nibble_q[2:0], checker_bit};
                    nibble_bits_q <= nibble_bits_q + 2'h1;
                    if (nibble_bits_q == 2'h3) begin
                        // Each repeat of a nibble value lowers the result by the square of its earlier count.
                        hist_q[{nibble_q[2:0], checker_bit}] <= hist_q[{nibble_q[2:0], checker_bit}] + 16'h0001;
                        poker_square_q <= poker_square_q - square_of_bin;
                    end
                end
            end
            // A new failure wins over a clear in the same cycle.
            if (period_end && (freq_low || freq_high)) begin
                freq_fail_q <= 1'b1;
            end else if (write_program && hwdata_i[`BIT_ERROR_STATUS]) begin
                freq_fail_q <= 1'b0;
            end
            if ((period_end && (freq_low || freq_high)) || sparse_fail || (run_done && poker_fail)) begin
                error_q <= 1'b1;
            end else if (write_program && hwdata_i[`BIT_ERROR_STATUS]) begin
                error_q <= 1'b0;
            end
        end
    end

    // Read data, answered in the data phase with no wait state.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            busy_o <= 1'b0;
            error_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            busy_o <= timer_busy;
            error_o <= error_q;
            hrdata_o <= 32'h00000000;
            if (access_now && !hwrite_i) begin
                case (req_addr)
                    `OFS_MISC_CONTROL: hrdata_o <= {15'h0000, program_mode_q, 3'h0, error_q, 1'b0,
                        1'b0, freq_valid_q, freq_fail_q, 2'h0, access_mode_q, 3'h0, sampling_method_q};
                    `OFS_POKER_SPAN: hrdata_o <= program_mode_q ? {16'h0000, poker_span_q} : 32'h00000000;
                    `OFS_POKER_LIMIT: hrdata_o <= program_mode_q ? pad(poker_limit_q) : pad(poker_square_q);
                    `OFS_SAMPLE_TIMING: hrdata_o <= program_mode_q ? {sample_length_q, sample_count_q}
                        : 32'h00000000;
                    `OFS_SPARSE_LIMIT: hrdata_o <= program_mode_q ? {22'h000000, sparse_limit_q}
                        : {{(32-TOTAL_W){1'b0}}, total_q};
                    `OFS_FREQ_LOWER: hrdata_o <= program_mode_q ? {{(32-FREQ_W){1'b0}}, freq_lower_q}
                        : 32'h00000000;
                    `OFS_FREQ_UPPER: hrdata_o <= program_mode_q ? {{(32-FREQ_W){1'b0}}, freq_upper_q}
                        : ((access_mode_q && entropy_select_q != `ENTROPY_SEL_OFF)
                        ? {{(32-FREQ_W){1'b0}}, freq_count_q} : 32'h00000000);
                    `OFS_OSC2_CONTROL: hrdata_o <= {30'h00000000, entropy_select_q};
                    default: hrdata_o <= {7'h00, poker_min};
                endcase
            end
        end
    end
endmodule // trng_health_limits

// ==== trng_health_limits_sva.sv ====
// Concurrent assertions for the entropy health limit register block.
`timescale 1ns/1ps
module trng_health_limits_sva #(
    parameter FREQ_W = 22,
    parameter TOTAL_W = 20
) (
    input wire clk_i,
    input wire rst_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    input wire [31:0] hrdata_o,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire osc_i,
    input wire raw_bit_i,
    input wire start_i,
    input wire busy_o,
    input wire error_o
);
    reg ph_act_q;
    reg ph_wr_q;
    reg [11:0] ph_addr_q;
    reg prog_q;
    wire taken = hsel_i && htrans_i[1] && hready_i;
    wire ctl_wr = ph_act_q && ph_wr_q && (ph_addr_q == 12'h600);
    wire clr_w = ctl_wr && hwdata_i[12];
    wire hid_rd = ph_act_q && !ph_wr_q && (ph_addr_q == 12'h610 || ph_addr_q == 12'h618);

    // Shadow of the program mode bit, updated in the write data phase.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_act_q <= 1'b0;
            ph_wr_q <= 1'b0;
            ph_addr_q <= 12'h000;
            prog_q <= 1'b0;
        end else begin
            ph_act_q <= taken;
            ph_wr_q <= hwrite_i;
            ph_addr_q <= haddr_i[11:0];
            if (ctl_wr) begin
                prog_q <= hwdata_i[16];
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ready_high: assert property (hreadyout_o == 1'b1) else $error("hreadyout low");
    a_resp_okay: assert property (hresp_o == 1'b0) else $error("hresp not okay");
    a_rdata_idle: assert property (!(taken && !hwrite_i) |=> hrdata_o == 32'h0) else $error("stale read data");
    a_limits_hidden: assert property (hid_rd && !prog_q && !$past(prog_q) |-> hrdata_o == 32'h0)
        else $error("limit visible outside program mode");
    a_restore_zero: assert property (ph_act_q && !ph_wr_q && ph_addr_q == 12'h600 |-> !hrdata_o[6])
        else $error("restore bit read as one");
    a_start_blocked: assert property (prog_q && $past(prog_q) && start_i && !busy_o |-> ##2 !busy_o)
        else $error("run started in program mode");
    a_error_hold: assert property ($fell(error_o) |-> $past(clr_w) || $past(clr_w, 2))
        else $error("error dropped without clear");
    a_busy_cause: assert property ($rose(busy_o) |-> $past(start_i) || $past(start_i, 2))
        else $error("run without start");

    cover property (taken && !hwrite_i);
    cover property ($rose(busy_o));
    cover property ($fell(error_o));
endmodule // trng_health_limits_sva

// ==== test_trng_health_limits.sv ====
// Self-checking testbench for the entropy health limit register block.
`timescale 1ns/1ps
module test_trng_health_limits;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg hsel_i = 1'b0;
    reg [31:0] haddr_i = 32'h0;
    reg [1:0] htrans_i = 2'h0;
    reg hwrite_i = 1'b0;
    reg [2:0] hsize_i = 3'h2;
    reg [31:0] hwdata_i = 32'h0;
    reg osc_i = 1'b0;
    reg raw_bit_i = 1'b0;
    reg start_i = 1'b0;
    reg osc_run = 1'b0;
    wire hready_i;
    wire [31:0] hrdata_o;
    wire hreadyout_o;
    wire hresp_o;
    wire busy_o;
    wire error_o;
    integer miscompares = 0;
    integer n_checks = 0;
    integer cycles = 0;
    integer len;
    integer s;
    reg [31:0] rd;

    assign hready_i = hreadyout_o;
    always #20 clk_i = ~clk_i;

    trng_health_limits u_dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .osc_i(osc_i),
        .raw_bit_i(raw_bit_i), .start_i(start_i), .busy_o(busy_o), .error_o(error_o));

    // Oscillator toggles every clock when running; a cycle count also bounds the whole test.
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (osc_run) begin
            osc_i <= ~osc_i;
        end
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end

    task final_report;
        begin
            if (miscompares == 0 && n_checks > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask

    task chk(input [8*10-1:0] name, input [31:0] exp, input [31:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    // One single transfer; called right after a rising edge, ends at the data-phase edge.
    task xfer(input wr, input [11:0] addr, input [31:0] wdata);
        begin
            hsel_i <= 1'b1;
            htrans_i <= 2'h2;
            haddr_i <= {20'h0, addr};
            hwrite_i <= wr;
            @(posedge clk_i);
            while (hready_i !== 1'b1) begin
                @(posedge clk_i);
            end
            hsel_i <= 1'b0;
            htrans_i <= 2'h0;
            hwdata_i <= wdata;
            @(posedge clk_i);
            while (hready_i !== 1'b1) begin
                @(posedge clk_i);
            end
            rd = hrdata_o;
        end
    endtask

    task rc(input [11:0] addr, input [31:0] exp);
        begin
            xfer(1'b0, addr, 32'h0);
            chk("register", exp, rd);
        end
    endtask

    task ctl_bit(input integer b, input e);
        begin
            xfer(1'b0, 12'h600, 32'h0);
            chk("ctl bit", {31'h0, e}, {31'h0, rd[b]});
        end
    endtask

    // Leaves program mode with the given control word, starts a run and measures busy.
    task run(input [31:0] ctl);
        begin
            xfer(1'b1, 12'h600, ctl);
            @(posedge clk_i);
            start_i <= 1'b1;
            @(posedge clk_i);
            start_i <= 1'b0;
            while (busy_o !== 1'b1) begin
                @(posedge clk_i);
            end
            len = 0;
            while (busy_o === 1'b1) begin
                @(posedge clk_i);
                len = len + 1;
            end
            @(posedge clk_i);
        end
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        xfer(1'b1, 12'h600, 32'h00010021);
        rc(12'h60C, 32'h00006920);
        rc(12'h610, 32'h0C8009C4);
        rc(12'h614, 32'h0000003F);
        rc(12'h618, 32'h00000190);
        rc(12'h61C, 32'h00006400);
        rc(12'h6F0, 32'h00005F7E);
        xfer(1'b1, 12'h60C, 32'hFF123456);
        rc(12'h60C, 32'h00123456);
        xfer(1'b1, 12'h618, 32'hFFFFFFFF);
        rc(12'h618, 32'h003FFFFF);
        xfer(1'b1, 12'h614, 32'h0000FFFF);
        rc(12'h614, 32'h000003FF);
        xfer(1'b1, 12'h600, 32'h00010061);
        ctl_bit(6, 1'b0);
        rc(12'h60C, 32'h00006920);
        rc(12'h618, 32'h00000190);
        for (s = 0; s < 3; s = s + 1) begin
            xfer(1'b1, 12'h600, 32'h00010020 | s);
            xfer(1'b0, 12'h600, 32'h0);
            chk("sampling", s, {30'h0, rd[1:0]});
        end
        xfer(1'b1, 12'h600, 32'h00000021);
        rc(12'h610, 32'h0);
        rc(12'h618, 32'h0);
        xfer(1'b1, 12'h610, 32'h00040003);
        xfer(1'b1, 12'h600, 32'h00010021);
        rc(12'h610, 32'h0C8009C4);
        xfer(1'b1, 12'h610, 32'h00080004);
        xfer(1'b1, 12'h618, 32'h00000003);
        xfer(1'b1, 12'h61C, 32'h003FFFFF);
        run(32'h00000021);
        chk("run len", 32, len);
        ctl_bit(8, 1'b1);
        chk("error", 1, {31'h0, error_o});
        rc(12'h614, 32'h00000004);
        xfer(1'b1, 12'h600, 32'h00000021);
        ctl_bit(8, 1'b1);
        xfer(1'b1, 12'h600, 32'h00001021);
        ctl_bit(8, 1'b0);
        chk("error", 0, {31'h0, error_o});
        xfer(1'b1, 12'h600, 32'h00000001);
        rc(12'h61C, 32'h0);
        xfer(1'b1, 12'h630, 32'h00000002);
        xfer(1'b1, 12'h600, 32'h00000021);
        rc(12'h61C, 32'h0);
        xfer(1'b1, 12'h630, 32'h00000000);
        xfer(1'b1, 12'h600, 32'h00010021);
        start_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        start_i <= 1'b0;
        chk("busy", 0, {31'h0, busy_o});
        xfer(1'b1, 12'h618, 32'h00000000);
        xfer(1'b1, 12'h61C, 32'h00000001);
        xfer(1'b1, 12'h610, 32'h00080008);
        osc_run <= 1'b1;
        run(32'h00000021);
        ctl_bit(8, 1'b1);
        ctl_bit(9, 1'b1);
        rc(12'h61C, 32'h00000004);
        rc(12'h60C, 32'h0000691F);
        xfer(1'b1, 12'h600, 32'h00011021);
        xfer(1'b1, 12'h61C, 32'h003FFFFF);
        xfer(1'b1, 12'h614, 32'h00000002);
        xfer(1'b1, 12'h610, 32'h00080010);
        raw_bit_i <= 1'b1;
        run(32'h00000020);
        ctl_bit(8, 1'b0);
        chk("error", 1, {31'h0, error_o});
        ctl_bit(12, 1'b1);
        final_report;
    end
endmodule // test_trng_health_limits

bind trng_health_limits trng_health_limits_sva #(.FREQ_W(FREQ_W), .TOTAL_W(TOTAL_W)) u_sva (.clk_i(clk_i),
    .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .osc_i(osc_i), .raw_bit_i(raw_bit_i), .start_i(start_i), .busy_o(busy_o),
    .error_o(error_o));
